// ### include/uafs_pkg.sv
/*
 * Constants for the UART FIFO level, reset and shadow control slice.
 * Assumes a 32-bit register port with word-aligned byte addresses.
 */
package uafs_pkg;
   localparam int ADDR_W = 32;
   localparam int DATA_W = 32;
   // Register byte addresses
   localparam logic [31:0] TX_LEVEL_ADDR = 32'h50001180;
   localparam logic [31:0] RX_LEVEL_ADDR = 32'h50001184;
   localparam logic [31:0] SOFT_RST_ADDR = 32'h50001188;
   localparam logic [31:0] FLOW_ALIAS_ADDR = 32'h5000118C;
   localparam logic [31:0] BREAK_ALIAS_ADDR = 32'h50001190;
   localparam logic [31:0] QUEUE_CTRL_ADDR = 32'h50001108;
   localparam logic [31:0] LINE_CTRL_ADDR = 32'h5000110C;
   localparam logic [31:0] MODEM_CTRL_ADDR = 32'h50001110;
   // Field positions
   localparam int SRR_TX_CLR_BIT = 2;
   localparam int SRR_RX_CLR_BIT = 1;
   localparam int SRR_CTRL_RST_BIT = 0;
   localparam int ALIAS_BIT = 0;
   localparam int MCR_RTS_BIT = 1;
   localparam int MCR_LOOP_BIT = 4;
   localparam int MCR_AFC_BIT = 5;
   localparam int MCR_IR_BIT = 6;
   localparam int LCR_BREAK_BIT = 6;
   localparam int QCR_EN_BIT = 0;
   localparam int QCR_RX_CLR_BIT = 1;
   localparam int QCR_TX_CLR_BIT = 2;
   localparam int QCR_TRIG_LO = 6;
   // Values after reset
   localparam logic [7:0] MCR_RST = 8'h00;
   localparam logic [7:0] LCR_RST = 8'h00;
   localparam logic [7:0] QCR_RST = 8'h00;
   localparam logic [15:0] LEVEL_RST = 16'h0000;
   // Sizes and cycle counts
   localparam int FIFO_DEPTH_DFLT = 16;
   localparam int RST_SYNC_STAGES = 2;
   localparam int IR_PERIOD_CYC = 16;
   localparam int IR_LOW_CYC = 3;
   // Receive trigger codes
   typedef enum logic [1:0] {
      UAFS_TRIG_ONE = 2'h0,
      UAFS_TRIG_QUARTER = 2'h1,
      UAFS_TRIG_HALF = 2'h2,
      UAFS_TRIG_TWO_LESS = 2'h3
   } uafs_trig_e;
endpackage

// ### include/uafs_pulse_if.sv
/*
 * Link between the controller and its infrared break pulse generator.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface uafs_pulse_if;
   logic en;
   logic pulse_n;
   modport gen (input en, output pulse_n);
   modport user (output en, input pulse_n);
endinterface

// ### verilog/uafs_rst_sync.sv
/*
 * Reset synchroniser: asserts at once, releases after a flop chain.
 * Assumes arst_n is glitch free (a flop output gated with the pin).
 */
`timescale 1ns/1ps
module uafs_rst_sync #(
   parameter int STAGES = uafs_pkg::RST_SYNC_STAGES
)(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic ce,
   // Synchronised reset
   output logic rst_n
);
   logic [STAGES-1:0] chain_r;

   if (STAGES < 2)
   begin : g_bad
      $error("uafs_rst_sync needs two stages or more");
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         chain_r <= '0;
      end
      else if (ce)
      begin
         chain_r <= {chain_r[STAGES-2:0], 1'b1};
      end
   end

   assign rst_n = chain_r[STAGES-1];
endmodule

// ### verilog/uafs_ir_pulse.sv
/*
 * Repeating active-low pulse for infrared break signalling.
 * Assumes the enable comes from logic on the same clock.
 */
`timescale 1ns/1ps
module uafs_ir_pulse #(
   parameter int PERIOD = uafs_pkg::IR_PERIOD_CYC,
   parameter int LOW = uafs_pkg::IR_LOW_CYC
)(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic ce,
   // Pulse link
   uafs_pulse_if.gen pif
);
   logic [7:0] cnt_r;
   logic pulse_n_r;

   if (PERIOD > 255 || LOW < 1 || LOW >= PERIOD)
   begin : g_bad
      $error("uafs_ir_pulse period or width out of range");
   end

   // Period counter
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_r <= 8'h00;
      end
      else if (ce)
      begin
         if (!pif.en || cnt_r == 8'(PERIOD - 1))
            cnt_r <= 8'h00;
         else
            cnt_r <= cnt_r + 8'h01;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pulse_n_r <= 1'b1;
      end
      else if (ce)
      begin
         pulse_n_r <= !(pif.en && cnt_r < 8'(LOW));
      end
   end

   assign pif.pulse_n = pulse_n_r;
endmodule

// ### verilog/uafs_top.sv
/*
 * UART slice: FIFO fill levels, soft resets, shadow flow and break bits,
 * and the flow, serial and infrared outputs they steer.
 * Assumes the data path gives push/pop pulses and serial bits on sys_clk.
 */
// How it works
// - Report transmit FIFO entry count, read only
// - Report receive FIFO entry count, read only
// - Soft bit two clears transmit FIFO
// - Soft bit one clears receive FIFO
// - Soft bit zero resets whole controller
// - Flow alias writes modem control request bit
// - Request output follows control bit normally
// - Auto flow blocks request at or above threshold if queue enabled
// - Loopback holds request high, loops back
// - Break alias writes line control break
// - Break forces serial output low unless in loopback
// - Infrared break pulses infrared output continuously unless in loopback
// - Loopback break goes to own receiver
// - Trigger code selects receive threshold level
`timescale 1ns/1ps
module uafs_top #(
   parameter int DEPTH = uafs_pkg::FIFO_DEPTH_DFLT
)(
   // Clock, reset, enable
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic ce,
   // Register port
   input wire logic [31:0] addr,
   input wire logic [31:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [31:0] rd_data,
   // Data path side
   input wire logic tx_push,
   input wire logic tx_pop,
   input wire logic rx_push,
   input wire logic rx_pop,
   input wire logic tx_bit,
   input wire logic ir_tx_n,
   output logic tx_queue_clear,
   output logic rx_queue_clear,
   output logic controller_soft_reset_n,
   output logic rx_serial,
   output logic cts_status,
   // Serial pins
   input wire logic sin,
   input wire logic cts_n,
   output logic sout,
   output logic rts_n,
   output logic sir_out_n
);
   logic soft_rst_r;
   logic rst_n;
   logic [7:0] mcr_r;
   logic [7:0] lcr_r;
   logic [7:0] qcr_r;
   logic [15:0] tx_level_r;
   logic [15:0] rx_level_r;
   logic tx_clr_r;
   logic rx_clr_r;
   logic [31:0] rd_data_r;
   logic rts_n_r;
   logic sout_r;
   logic sir_r;
   logic rx_serial_r;
   logic cts_status_r;
   logic sin_meta_r;
   logic sin_sync_r;
   logic cts_meta_r;
   logic cts_sync_r;
   logic wr_hit;
   logic tx_clr_nxt;
   logic rx_clr_nxt;
   logic [15:0] rx_thresh;
   logic rx_above;
   logic loop_on;
   logic brk_on;
   logic ir_on;
   logic [15:0] ir_high_run;
   uafs_pulse_if pif ();

   if (DEPTH < 4 || DEPTH > 65535)
   begin : g_bad
      $error("uafs_top DEPTH must be 4 to 65535");
   end

   assign wr_hit = wr_en && ce;
   assign loop_on = mcr_r[uafs_pkg::MCR_LOOP_BIT];
   assign brk_on = lcr_r[uafs_pkg::LCR_BREAK_BIT];
   assign ir_on = mcr_r[uafs_pkg::MCR_IR_BIT];

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         soft_rst_r <= 1'b0;
      end
      else if (ce)
      begin
         soft_rst_r <= wr_en && addr == uafs_pkg::SOFT_RST_ADDR && wr_data[uafs_pkg::SRR_CTRL_RST_BIT];
      end
   end

   uafs_rst_sync #(
      .STAGES(uafs_pkg::RST_SYNC_STAGES)
   ) u_rst_sync (
      .sys_clk(sys_clk),
      .arst_n(reset_n && !soft_rst_r),
      .ce(ce),
      .rst_n(rst_n)
   );

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mcr_r <= uafs_pkg::MCR_RST;
      end
      else if (wr_hit && addr == uafs_pkg::MODEM_CTRL_ADDR)
      begin
         mcr_r <= wr_data[7:0];
      end
      else if (wr_hit && addr == uafs_pkg::FLOW_ALIAS_ADDR)
      begin
         mcr_r[uafs_pkg::MCR_RTS_BIT] <= wr_data[uafs_pkg::ALIAS_BIT];
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         lcr_r <= uafs_pkg::LCR_RST;
      end
      else if (wr_hit && addr == uafs_pkg::LINE_CTRL_ADDR)
      begin
         lcr_r <= wr_data[7:0];
      end
      else if (wr_hit && addr == uafs_pkg::BREAK_ALIAS_ADDR)
      begin
         lcr_r[uafs_pkg::LCR_BREAK_BIT] <= wr_data[uafs_pkg::ALIAS_BIT];
      end
   end

   // Queue control, clear bits not stored
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         qcr_r <= uafs_pkg::QCR_RST;
      end
      else if (wr_hit && addr == uafs_pkg::QUEUE_CTRL_ADDR)
      begin
         qcr_r <= wr_data[7:0] & 8'hF9;
      end
   end

   always_comb
   begin
      tx_clr_nxt = 1'b0;
      rx_clr_nxt = 1'b0;
      if (wr_hit && addr == uafs_pkg::SOFT_RST_ADDR)
      begin
         tx_clr_nxt = wr_data[uafs_pkg::SRR_TX_CLR_BIT];
         rx_clr_nxt = wr_data[uafs_pkg::SRR_RX_CLR_BIT];
      end
      else if (wr_hit && addr == uafs_pkg::QUEUE_CTRL_ADDR)
      begin
         tx_clr_nxt = wr_data[uafs_pkg::QCR_TX_CLR_BIT];
         rx_clr_nxt = wr_data[uafs_pkg::QCR_RX_CLR_BIT];
         if (qcr_r[uafs_pkg::QCR_EN_BIT] && !wr_data[uafs_pkg::QCR_EN_BIT])
         begin
            tx_clr_nxt = 1'b1;
            rx_clr_nxt = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_clr_r <= 1'b0;
         rx_clr_r <= 1'b0;
      end
      else if (ce)
      begin
         tx_clr_r <= tx_clr_nxt;
         rx_clr_r <= rx_clr_nxt;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_level_r <= uafs_pkg::LEVEL_RST;
      end
      else if (ce)
      begin
         if (tx_clr_nxt)
            tx_level_r <= uafs_pkg::LEVEL_RST;
         else if (tx_push && !tx_pop && tx_level_r != 16'(DEPTH))
            tx_level_r <= tx_level_r + 16'h0001;
         else if (tx_pop && !tx_push && tx_level_r != 16'h0000)
            tx_level_r <= tx_level_r - 16'h0001;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_level_r <= uafs_pkg::LEVEL_RST;
      end
      else if (ce)
      begin
         if (rx_clr_nxt)
            rx_level_r <= uafs_pkg::LEVEL_RST;
         else if (rx_push && !rx_pop && rx_level_r != 16'(DEPTH))
            rx_level_r <= rx_level_r + 16'h0001;
         else if (rx_pop && !rx_push && rx_level_r != 16'h0000)
            rx_level_r <= rx_level_r - 16'h0001;
      end
   end

   // Register read port
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rd_data_r <= 32'h00000000;
      end
      else if (ce)
      begin
         if (!rd_en)
            rd_data_r <= 32'h00000000;
         else if (addr == uafs_pkg::TX_LEVEL_ADDR)
            rd_data_r <= {16'h0000, tx_level_r};
         else if (addr == uafs_pkg::RX_LEVEL_ADDR)
            rd_data_r <= {16'h0000, rx_level_r};
         else if (addr == uafs_pkg::FLOW_ALIAS_ADDR)
            rd_data_r <= {31'h00000000, mcr_r[uafs_pkg::MCR_RTS_BIT]};
         else if (addr == uafs_pkg::BREAK_ALIAS_ADDR)
            rd_data_r <= {31'h00000000, lcr_r[uafs_pkg::LCR_BREAK_BIT]};
         else if (addr == uafs_pkg::MODEM_CTRL_ADDR)
            rd_data_r <= {24'h000000, mcr_r};
         else if (addr == uafs_pkg::LINE_CTRL_ADDR)
            rd_data_r <= {24'h000000, lcr_r};
         else if (addr == uafs_pkg::QUEUE_CTRL_ADDR)
            rd_data_r <= {24'h000000, qcr_r};
         else
            rd_data_r <= 32'h00000000;
      end
   end

   always_comb
   begin
      case (uafs_pkg::uafs_trig_e'(qcr_r[uafs_pkg::QCR_TRIG_LO +: 2]))
         uafs_pkg::UAFS_TRIG_ONE: rx_thresh = 16'h0001;
         uafs_pkg::UAFS_TRIG_QUARTER: rx_thresh = 16'(DEPTH / 4);
         uafs_pkg::UAFS_TRIG_HALF: rx_thresh = 16'(DEPTH / 2);
         default: rx_thresh = 16'(DEPTH - 2);
      endcase
   end
   assign rx_above = rx_level_r >= rx_thresh;

   // Pin synchronisers
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sin_meta_r <= 1'b1;
         sin_sync_r <= 1'b1;
         cts_meta_r <= 1'b1;
         cts_sync_r <= 1'b1;
      end
      else if (ce)
      begin
         sin_meta_r <= sin;
         sin_sync_r <= sin_meta_r;
         cts_meta_r <= cts_n;
         cts_sync_r <= cts_meta_r;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rts_n_r <= 1'b1;
      end
      else if (ce)
      begin
         if (loop_on)
            rts_n_r <= 1'b1;
         else if (mcr_r[uafs_pkg::MCR_AFC_BIT] && qcr_r[uafs_pkg::QCR_EN_BIT] && rx_above)
            rts_n_r <= 1'b1;
         else
            rts_n_r <= !mcr_r[uafs_pkg::MCR_RTS_BIT];
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sout_r <= 1'b1;
         rx_serial_r <= 1'b1;
         cts_status_r <= 1'b0;
      end
      else if (ce)
      begin
         sout_r <= loop_on || (!brk_on && tx_bit);
         rx_serial_r <= loop_on ? (!brk_on && tx_bit) : sin_sync_r;
         cts_status_r <= loop_on ? mcr_r[uafs_pkg::MCR_RTS_BIT] : !cts_sync_r;
      end
   end

   assign pif.en = brk_on && ir_on && !loop_on;
   uafs_ir_pulse #(
      .PERIOD(uafs_pkg::IR_PERIOD_CYC),
      .LOW(uafs_pkg::IR_LOW_CYC)
   ) u_ir_pulse (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .ce(ce),
      .pif(pif)
   );

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sir_r <= 1'b1;
      end
      else if (ce)
      begin
         if (loop_on || !ir_on)
            sir_r <= 1'b1;
         else
            sir_r <= brk_on ? pif.pulse_n : ir_tx_n;
      end
   end

   assign rd_data = rd_data_r;
   assign tx_queue_clear = tx_clr_r;
   assign rx_queue_clear = rx_clr_r;
   assign controller_soft_reset_n = rst_n;
   assign rx_serial = rx_serial_r;
   assign cts_status = cts_status_r;
   assign sout = sout_r;
   assign rts_n = rts_n_r;
   assign sir_out_n = sir_r;

   // Helper: run of high infrared output during break
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         ir_high_run <= 16'h0000;
      else if (pif.en && sir_r && ce)
         ir_high_run <= ir_high_run + 16'h0001;
      else if (ce)
         ir_high_run <= 16'h0000;
   end

   property p_tx_count;
      @(posedge sys_clk) disable iff (!rst_n)
      ce && tx_push && !tx_pop && !tx_clr_nxt && tx_level_r < 16'(DEPTH) |=> tx_level_r == $past(tx_level_r) + 16'h0001;
   endproperty
   a_tx_count: assert property (p_tx_count) else $error("tx level did not count up");

   property p_rx_count;
      @(posedge sys_clk) disable iff (!rst_n)
      ce && rx_pop && !rx_push && !rx_clr_nxt && rx_level_r != 16'h0000 |=> rx_level_r == $past(rx_level_r) - 16'h0001;
   endproperty
   a_rx_count: assert property (p_rx_count) else $error("rx level did not count down");

   property p_tx_clear;
      @(posedge sys_clk) disable iff (!rst_n)
      wr_hit && addr == uafs_pkg::SOFT_RST_ADDR && wr_data[2] |=> tx_level_r == 16'h0000 && tx_queue_clear;
   endproperty
   a_tx_clear: assert property (p_tx_clear) else $error("tx clear missed");

   property p_rx_clear;
      @(posedge sys_clk) disable iff (!rst_n)
      wr_hit && addr == uafs_pkg::SOFT_RST_ADDR && wr_data[1] |=> rx_level_r == 16'h0000 && rx_queue_clear;
   endproperty
   a_rx_clear: assert property (p_rx_clear) else $error("rx clear missed");

   property p_soft_reset;
      @(posedge sys_clk) disable iff (!reset_n)
      wr_hit && addr == uafs_pkg::SOFT_RST_ADDR && wr_data[0] |-> ##2 !controller_soft_reset_n;
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("soft reset not asserted");

   property p_flow_alias;
      @(posedge sys_clk) disable iff (!rst_n)
      wr_hit && addr == uafs_pkg::FLOW_ALIAS_ADDR |=> mcr_r[1] == $past(wr_data[0]) && mcr_r[7:2] == $past(mcr_r[7:2]);
   endproperty
   a_flow_alias: assert property (p_flow_alias) else $error("flow alias not stored");

   property p_rts_plain;
      @(posedge sys_clk) disable iff (!rst_n)
      ce && !loop_on && !mcr_r[5] |=> rts_n == !$past(mcr_r[1]);
   endproperty
   a_rts_plain: assert property (p_rts_plain) else $error("rts_n not following control bit");

   property p_rts_gate;
      @(posedge sys_clk) disable iff (!rst_n)
      ce && mcr_r[5] && qcr_r[0] && rx_level_r >= rx_thresh |=> rts_n;
   endproperty
   a_rts_gate: assert property (p_rts_gate) else $error("rts_n active above threshold");

   property p_rts_loop;
      @(posedge sys_clk) disable iff (!rst_n)
      ce && loop_on |=> rts_n && cts_status == $past(mcr_r[1]);
   endproperty
   a_rts_loop: assert property (p_rts_loop) else $error("loopback rts wrong");

   property p_break_alias;
      @(posedge sys_clk) disable iff (!rst_n)
      wr_hit && addr == uafs_pkg::BREAK_ALIAS_ADDR |=> lcr_r[6] == $past(wr_data[0]);
   endproperty
   a_break_alias: assert property (p_break_alias) else $error("break alias not stored");

   property p_break_out;
      @(posedge sys_clk) disable iff (!rst_n)
      ce && brk_on && !loop_on |=> !sout;
   endproperty
   a_break_out: assert property (p_break_out) else $error("sout not low in break");

   property p_ir_pulse;
      @(posedge sys_clk) disable iff (!rst_n)
      ir_high_run <= 16'(uafs_pkg::IR_PERIOD_CYC + 2);
   endproperty
   a_ir_pulse: assert property (p_ir_pulse) else $error("infrared break not pulsing");

   property p_break_loop;
      @(posedge sys_clk) disable iff (!rst_n)
      ce && brk_on && loop_on |=> !rx_serial && sout;
   endproperty
   a_break_loop: assert property (p_break_loop) else $error("loopback break wrong");

   property p_thresh;
      @(posedge sys_clk) disable iff (!rst_n)
      qcr_r[7:6] == 2'h3 |-> rx_thresh == 16'(DEPTH - 2);
   endproperty
   a_thresh: assert property (p_thresh) else $error("two-less threshold wrong");
endmodule

// ### tb/uafs_modem.sv
/*
 * Modem model on the serial side: drives the line, answers flow requests.
 * Assumes the bench sets the line level through line_val.
 */
`timescale 1ns/1ps
module uafs_modem #(
   parameter int LAG = 2
)(
   // Clock
   input wire logic sys_clk,
   // Bench control
   input wire logic line_val,
   // Serial pins
   input wire logic rts_n,
   input wire logic sout,
   output logic sin,
   output logic cts_n
);
   logic [7:0] lag_r = 8'hFF;
   assign sin = line_val;
   // Grant clear to send a few cycles after a request
   always @(posedge sys_clk)
   begin
      lag_r <= {lag_r[6:0], rts_n};
   end
   assign cts_n = lag_r[LAG-1];
endmodule

// ### tb/tb_top.sv
/*
 * Self-checking bench for the FIFO level, soft reset and shadow slice.
 * Assumes uafs_top and the modem model; the clock enable stays high.
 */
`timescale 1ns/1ps
module tb_top;
   localparam int DEPTH = 8;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [31:0] addr = 32'h0;
   logic [31:0] wr_data = 32'h0;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic [3:0] dp = 4'h0;
   logic tx_bit = 1'b1;
   logic ir_tx_n = 1'b1;
   logic line_val = 1'b1;
   logic [31:0] rd_data;
   logic txc, rxc, crst_n, rx_serial, cts_status, sin, cts_n, sout, rts_n, sir_out_n;
   int bad_count = 0;
   int checks = 0;

   uafs_top #(.DEPTH(DEPTH)) dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .ce(1'b1), .addr(addr),
      .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .tx_push(dp[3]),
      .tx_pop(dp[2]), .rx_push(dp[1]), .rx_pop(dp[0]), .tx_bit(tx_bit), .ir_tx_n(ir_tx_n),
      .tx_queue_clear(txc), .rx_queue_clear(rxc), .controller_soft_reset_n(crst_n),
      .rx_serial(rx_serial), .cts_status(cts_status), .sin(sin), .cts_n(cts_n), .sout(sout),
      .rts_n(rts_n), .sir_out_n(sir_out_n));
   uafs_modem modem_u (.sys_clk(sys_clk), .line_val(line_val), .rts_n(rts_n), .sout(sout),
      .sin(sin), .cts_n(cts_n));

   initial
   begin
      forever #4 sys_clk = ~sys_clk;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e)
      begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge sys_clk);
      wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] e, input string nm);
      @(posedge sys_clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge sys_clk);
      rd_en <= 1'b0;
      #1;
      chk(nm, e, rd_data);
   endtask
   // Data path pulses, back to back
   task automatic dp_run(input logic [3:0] v, input int n);
      repeat (n) @(posedge sys_clk) dp <= v;
      @(posedge sys_clk);
      dp <= 4'h0;
   endtask

   task automatic t_reset;
      rd(uafs_pkg::TX_LEVEL_ADDR, 32'h0, "tx level");
      rd(uafs_pkg::RX_LEVEL_ADDR, 32'h0, "rx level");
      rd(uafs_pkg::SOFT_RST_ADDR, 32'h0, "soft reset");
      rd(uafs_pkg::FLOW_ALIAS_ADDR, 32'h0, "flow alias");
      rd(uafs_pkg::BREAK_ALIAS_ADDR, 32'h0, "break alias");
      rd(32'h50001000, 32'h0, "unmapped");
      chk("rts_n", 32'h1, {31'h0, rts_n});
      $display("done reset");
   endtask

   task automatic t_levels;
      dp_run(4'h8, DEPTH + 1);
      rd(uafs_pkg::TX_LEVEL_ADDR, DEPTH, "tx full");
      dp_run(4'h2, 5);
      dp_run(4'h1, 2);
      rd(uafs_pkg::RX_LEVEL_ADDR, 32'h3, "rx level");
      dp_run(4'hC, 2);
      rd(uafs_pkg::TX_LEVEL_ADDR, DEPTH, "tx hold");
      wr(uafs_pkg::SOFT_RST_ADDR, 32'h4);
      #1;
      chk("tx clear", 32'h1, {31'h0, txc});
      tick(1);
      chk("tx clear end", 32'h0, {31'h0, txc});
      rd(uafs_pkg::TX_LEVEL_ADDR, 32'h0, "tx cleared");
      rd(uafs_pkg::RX_LEVEL_ADDR, 32'h3, "rx kept");
      wr(uafs_pkg::SOFT_RST_ADDR, 32'h2);
      #1;
      chk("rx clear", 32'h1, {31'h0, rxc});
      rd(uafs_pkg::RX_LEVEL_ADDR, 32'h0, "rx cleared");
      $display("done levels");
   endtask

   task automatic t_rts;
      wr(uafs_pkg::FLOW_ALIAS_ADDR, 32'h1);
      tick(2);
      chk("rts_n on", 32'h0, {31'h0, rts_n});
      rd(uafs_pkg::MODEM_CTRL_ADDR, 32'h2, "modem ctrl");
      rd(uafs_pkg::FLOW_ALIAS_ADDR, 32'h1, "flow alias");
      tick(8);
      chk("cts status", 32'h1, {31'h0, cts_status});
      wr(uafs_pkg::MODEM_CTRL_ADDR, 32'h0);
      rd(uafs_pkg::FLOW_ALIAS_ADDR, 32'h0, "flow alias");
      tick(1);
      chk("rts_n off", 32'h1, {31'h0, rts_n});
      $display("done rts");
   endtask

   task automatic t_afc;
      int th [4];
      th = '{1, DEPTH / 4, DEPTH / 2, DEPTH - 2};
      for (int c = 0; c < 4; c++)
      begin
         wr(uafs_pkg::MODEM_CTRL_ADDR, 32'h22);
         wr(uafs_pkg::QUEUE_CTRL_ADDR, 32'h1 | (c << 6));
         wr(uafs_pkg::SOFT_RST_ADDR, 32'h2);
         dp_run(4'h2, th[c] - 1);
         tick(2);
         chk("afc below", 32'h0, {31'h0, rts_n});
         dp_run(4'h2, 1);
         tick(2);
         chk("afc at", 32'h1, {31'h0, rts_n});
      end
      wr(uafs_pkg::QUEUE_CTRL_ADDR, 32'h0);
      wr(uafs_pkg::MODEM_CTRL_ADDR, 32'h0);
      $display("done afc");
   endtask

   task automatic t_loop;
      wr(uafs_pkg::MODEM_CTRL_ADDR, 32'h12);
      tick(3);
      chk("loop rts_n", 32'h1, {31'h0, rts_n});
      chk("loop cts", 32'h1, {31'h0, cts_status});
      chk("loop rx", 32'h1, {31'h0, rx_serial});
      wr(uafs_pkg::BREAK_ALIAS_ADDR, 32'h1);
      tick(2);
      chk("loop sout", 32'h1, {31'h0, sout});
      chk("loop brk rx", 32'h0, {31'h0, rx_serial});
      wr(uafs_pkg::MODEM_CTRL_ADDR, 32'h0);
      tick(2);
      chk("break sout", 32'h0, {31'h0, sout});
      rd(uafs_pkg::LINE_CTRL_ADDR, 32'h40, "line ctrl");
      wr(uafs_pkg::LINE_CTRL_ADDR, 32'h0);
      rd(uafs_pkg::BREAK_ALIAS_ADDR, 32'h0, "break alias");
      @(posedge sys_clk);
      tx_bit <= 1'b0;
      line_val <= 1'b0;
      tick(5);
      chk("sout data", 32'h0, {31'h0, sout});
      chk("rx line", 32'h0, {31'h0, rx_serial});
      @(posedge sys_clk);
      tx_bit <= 1'b1;
      line_val <= 1'b1;
      tick(5);
      chk("rx line", 32'h1, {31'h0, rx_serial});
      $display("done loop");
   endtask

   task automatic t_ir;
      int n;
      n = 0;
      wr(uafs_pkg::MODEM_CTRL_ADDR, 32'h40);
      ir_tx_n <= 1'b0;
      tick(2);
      chk("ir data", 32'h0, {31'h0, sir_out_n});
      @(posedge sys_clk);
      ir_tx_n <= 1'b1;
      wr(uafs_pkg::BREAK_ALIAS_ADDR, 32'h1);
      tick(3);
      repeat (2 * uafs_pkg::IR_PERIOD_CYC)
      begin
         tick(1);
         if (sir_out_n === 1'b0)
            n++;
      end
      chk("ir pulses", 2 * uafs_pkg::IR_LOW_CYC, 32'(n));
      wr(uafs_pkg::BREAK_ALIAS_ADDR, 32'h0);
      wr(uafs_pkg::MODEM_CTRL_ADDR, 32'h0);
      $display("done ir");
   endtask

   task automatic t_soft;
      logic seen;
      seen = 1'b0;
      wr(uafs_pkg::FLOW_ALIAS_ADDR, 32'h1);
      dp_run(4'h8, 2);
      wr(uafs_pkg::SOFT_RST_ADDR, 32'h1);
      repeat (4)
      begin
         tick(1);
         if (crst_n === 1'b0)
            seen = 1'b1;
      end
      chk("soft rst low", 32'h1, {31'h0, seen});
      tick(8);
      chk("soft rst end", 32'h1, {31'h0, crst_n});
      rd(uafs_pkg::TX_LEVEL_ADDR, 32'h0, "tx level");
      rd(uafs_pkg::FLOW_ALIAS_ADDR, 32'h0, "flow alias");
      $display("done soft reset");
   endtask

   task automatic close_out;
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial
   begin
      #200000;
      bad_count++;
      close_out();
   end

   initial
   begin
      repeat (12) @(posedge sys_clk);
      reset_n <= 1'b1;
      tick(4);
      t_reset();
      t_levels();
      t_rts();
      t_afc();
      t_loop();
      t_ir();
      t_soft();
      close_out();
   end
endmodule
